// *** rtl/fsl_load_unit.sv ***
// datapath of the single precision floating point load group with apb status registers
// Functional notes
// - opcode 4E in the storage forms and 1E as its register form are the raw load.
// - the raw load copies the 32-bit operand unchanged into the destination register.
// - opcode 68 is the normalizing load from memory, 28 from an fp register, A5 from a gpr.
// - normalizing loads normalize the source when needed and write it to the destination.
// - a zero fraction in normalizing, positive or negated loads yields an all-zero word.
// - underflow with status bit 19 set raises an arithmetic fault and writes only the condition code.
// - underflow with status bit 19 clear raises no fault and writes zero.
// - opcode 13 is the load positive register form, source chosen by src_reg_field.
// - load positive clears the sign, normalizes when needed and writes the destination.
// - opcode 17 is the load negated register form, which inverts the source sign.
// - after the sign inversion the value is normalized when needed before the write.
// - condition code is 0000 zero, 0001 negative, 0010 positive, 0100 on underflow.
// - every instruction is illegal while float_mask_bit, status bit 13, is set.
`timescale 1ns/1ps
`include "fsl_regs.svh"
module fsl_load_unit (
   input  wire logic                     pclk,         // processor clock, 100 MHz
   input  wire logic                     presetn,      // async reset, active low
   input  wire logic                     psel,         // apb select
   input  wire logic                     penable,      // apb access phase
   input  wire logic                     pwrite,       // apb write
   input  wire logic [`FSL_ADDR_W-1:0]   paddr,        // apb byte address
   input  wire logic [31:0]              pwdata,       // apb write data
   output logic      [31:0]              prdata,       // apb read data
   output logic                          pready,       // apb ready
   output logic                          pslverr,      // apb error, unmapped address
   input  wire logic                     req_valid,    // decoder offers an instruction
   input  wire fsl_pkg::fsl_req_t        req,          // instruction bundle
   output logic                          req_ready,    // unit takes the instruction
   output logic      [3:0]               fpr_rd_addr,  // fpr file read index
   input  wire logic [31:0]              fpr_rd_data,  // fpr file read data
   output logic      [3:0]               gpr_rd_addr,  // gpr file read index
   input  wire logic [31:0]              gpr_rd_data,  // gpr file read data
   output logic                          fpr_wr_en,    // fpr file write strobe
   output logic      [3:0]               fpr_wr_addr,  // fpr file write index
   output logic      [31:0]              fpr_wr_data,  // fpr file write data
   output logic                          cc_wr_en,     // condition code write strobe
   output fsl_pkg::fsl_cc_t              cc_value,     // condition code value
   output logic                          arith_fault,  // arithmetic fault interrupt
   output logic                          illegal_op,   // illegal instruction
   output logic                          done,         // instruction retired
   output logic                          irq           // unmasked status pending
);
   fsl_pkg::fsl_ctx_t r;
   fsl_pkg::fsl_ctx_t next_r;
   fsl_pkg::fsl_evt_t evt_set;
   fsl_pkg::fsl_evt_t evt_clr;
   logic [31:0]       src_val;
   logic [31:0]       norm_result;
   logic              norm_uflow;
   logic              norm_zero;
   logic              take;
   logic              op_known;
   logic              op_raw;
   logic              apb_ans;
   logic              apb_wr;
   logic              rd_hit;
   logic [31:0]       rd_word;

   function automatic fsl_pkg::fsl_cc_t cc_of(input logic [31:0] v);
      if (v == 32'h00000000) begin
         cc_of = fsl_pkg::fsl_cc_t'(`FSL_CC_ZERO);
      end else if (v[31]) begin
         cc_of = fsl_pkg::fsl_cc_t'(`FSL_CC_NEG);
      end else begin
         cc_of = fsl_pkg::fsl_cc_t'(`FSL_CC_POS);
      end
   endfunction : cc_of

   assign take = req_valid & r.ready;

   always_comb begin
      case (req.opcode)
         `FSL_OP_RAW_MEM, `FSL_OP_RAW_REG:                   op_known = 1'b1;
         `FSL_OP_NORM_MEM, `FSL_OP_NORM_REG, `FSL_OP_NORM_GPR: op_known = 1'b1;
         `FSL_OP_POS_REG:                                    op_known = 1'b1;
         `FSL_OP_NEG_REG:                                    op_known = 1'b1;
         default:                                            op_known = 1'b0;
      endcase
   end

   assign op_raw = (r.req.opcode == `FSL_OP_RAW_MEM) || (r.req.opcode == `FSL_OP_RAW_REG);

   always_comb begin
      case (r.req.opcode)
         `FSL_OP_RAW_MEM, `FSL_OP_NORM_MEM: src_val = r.req.mem_data;
         `FSL_OP_NORM_GPR:                  src_val = gpr_rd_data;
         `FSL_OP_POS_REG:                   src_val = {1'b0, fpr_rd_data[30:0]};
         `FSL_OP_NEG_REG:                   src_val = fpr_rd_data ^ 32'h80000000;
         default:                           src_val = fpr_rd_data;
      endcase
   end

   fsl_norm u_norm (
      .value_in  (src_val),
      .result    (norm_result),
      .underflow (norm_uflow),
      .frac_zero (norm_zero)
   );

   always_comb begin
      case (paddr)
         `FSL_OFF_CTRL:   rd_word = {31'h00000000, r.enable};
         `FSL_OFF_STATUS: rd_word = {28'h0000000, r.status};
         `FSL_OFF_MASK:   rd_word = {28'h0000000, r.mask};
         `FSL_OFF_RESULT: rd_word = r.last_result;
         `FSL_OFF_CC:     rd_word = {28'h0000000, r.cc};
         `FSL_OFF_COUNT:  rd_word = r.op_count;
         default:         rd_word = 32'h00000000;
      endcase
      case (paddr)
         `FSL_OFF_CTRL, `FSL_OFF_STATUS, `FSL_OFF_MASK,
         `FSL_OFF_RESULT, `FSL_OFF_CC, `FSL_OFF_COUNT: rd_hit = 1'b1;
         default:                                      rd_hit = 1'b0;
      endcase
   end

   // first access cycle computes the answer, the write lands on the edge that sees pready
   assign apb_ans = psel & penable & ~r.pready;
   assign apb_wr  = psel & penable & r.pready & pwrite;

   always_comb begin
      next_r           = r;
      next_r.fpr_wr_en = 1'b0;
      next_r.cc_wr_en  = 1'b0;
      next_r.fault     = 1'b0;
      next_r.illegal   = 1'b0;
      next_r.done      = 1'b0;
      evt_set          = '0;
      evt_clr          = '0;
      case (r.st)
         fsl_pkg::ST_IDLE: begin
            if (take) begin
               next_r.req = req;
               if (req.float_mask || !op_known) begin
                  next_r.illegal  = 1'b1;
                  evt_set.illegal = 1'b1;
               end else begin
                  next_r.st          = fsl_pkg::ST_FETCH;
                  next_r.fpr_rd_addr = req.src;
                  next_r.gpr_rd_addr = req.src;
               end
            end
         end
         fsl_pkg::ST_FETCH: begin
            next_r.st          = fsl_pkg::ST_IDLE;
            next_r.done        = 1'b1;
            evt_set.done       = 1'b1;
            next_r.cc_wr_en    = 1'b1;
            next_r.fpr_wr_addr = r.req.dest;
            if (op_raw) begin
               next_r.fpr_wr_en   = 1'b1;
               next_r.fpr_wr_data = src_val;
               next_r.cc          = cc_of(src_val);
            end else if (norm_zero) begin
               next_r.fpr_wr_en   = 1'b1;
               next_r.fpr_wr_data = 32'h00000000;
               next_r.cc          = fsl_pkg::fsl_cc_t'(`FSL_CC_ZERO);
            end else if (norm_uflow) begin
               next_r.cc     = fsl_pkg::fsl_cc_t'(`FSL_CC_UFLOW);
               evt_set.uflow = 1'b1;
               if (r.req.uflow_trap) begin
                  next_r.fault  = 1'b1;
                  evt_set.fault = 1'b1;
               end else begin
                  next_r.fpr_wr_en   = 1'b1;
                  next_r.fpr_wr_data = 32'h00000000;
               end
            end else begin
               // positive and negated forms reach here with the sign already fixed
               next_r.fpr_wr_en   = 1'b1;
               next_r.fpr_wr_data = norm_result;
               next_r.cc          = cc_of(norm_result);
            end
         end
         default: begin
            next_r.st = fsl_pkg::ST_IDLE;
         end
      endcase
      if (next_r.fpr_wr_en) begin
         next_r.last_result = next_r.fpr_wr_data;
      end
      if (next_r.done) begin
         next_r.op_count = r.op_count + 32'h00000001;
      end
      next_r.pready  = apb_ans;
      next_r.pslverr = apb_ans & ~rd_hit;
      next_r.prdata  = (apb_ans && !pwrite) ? rd_word : 32'h00000000;
      if (apb_wr) begin
         case (paddr)
            `FSL_OFF_CTRL:   next_r.enable = pwdata[`FSL_CTRL_EN_BIT];
            `FSL_OFF_STATUS: evt_clr       = fsl_pkg::fsl_evt_t'(pwdata[`FSL_EVT_W-1:0]);
            `FSL_OFF_MASK:   next_r.mask   = fsl_pkg::fsl_evt_t'(pwdata[`FSL_EVT_W-1:0]);
            default: begin
            end
         endcase
      end
      // set beats a same-cycle write-one-to-clear so no event is lost
      next_r.status = (r.status & ~evt_clr) | evt_set;
      next_r.irq    = |(next_r.status & next_r.mask);
      // disabling only stops new instructions, one in flight still retires
      next_r.ready  = next_r.enable && (next_r.st == fsl_pkg::ST_IDLE);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r        <= '0;
         r.st     <= fsl_pkg::ST_IDLE;
         r.enable <= `FSL_CTRL_EN_RST;
         r.ready  <= `FSL_CTRL_EN_RST;
         r.status <= `FSL_STATUS_RST;
         r.mask   <= `FSL_MASK_RST;
      end else begin
         r <= next_r;
      end
   end

   assign prdata      = r.prdata;
   assign pready      = r.pready;
   assign pslverr     = r.pslverr;
   assign req_ready   = r.ready;
   assign fpr_rd_addr = r.fpr_rd_addr;
   assign gpr_rd_addr = r.gpr_rd_addr;
   assign fpr_wr_en   = r.fpr_wr_en;
   assign fpr_wr_addr = r.fpr_wr_addr;
   assign fpr_wr_data = r.fpr_wr_data;
   assign cc_wr_en    = r.cc_wr_en;
   assign cc_value    = r.cc;
   assign arith_fault = r.fault;
   assign illegal_op  = r.illegal;
   assign done        = r.done;
   assign irq         = r.irq;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic legal_take;
   assign legal_take = take & ~req.float_mask & op_known;

   property p_legal_retires;
      legal_take |-> ##1 !done ##1 (done && cc_wr_en && !illegal_op);
   endproperty
   a_legal_retires: assert property (p_legal_retires) else $error("legal op did not retire");

   property p_masked_illegal;
      take && req.float_mask |=> illegal_op && !fpr_wr_en ##1 !fpr_wr_en && !done;
   endproperty
   a_masked_illegal: assert property (p_masked_illegal) else $error("masked op executed");

   property p_raw_copy;
      legal_take && req.opcode == `FSL_OP_RAW_MEM
         |-> ##2 fpr_wr_en && fpr_wr_data == $past(req.mem_data, 2);
   endproperty
   a_raw_copy: assert property (p_raw_copy) else $error("raw load altered data");

   property p_cc_sign;
      fpr_wr_en && fpr_wr_data != 32'h00000000
         |-> cc_value == (fpr_wr_data[31] ? `FSL_CC_NEG : `FSL_CC_POS);
   endproperty
   a_cc_sign: assert property (p_cc_sign) else $error("cc does not match result sign");

   property p_fault_no_write;
      arith_fault |-> !fpr_wr_en && cc_wr_en && cc_value == `FSL_CC_UFLOW;
   endproperty
   a_fault_no_write: assert property (p_fault_no_write) else $error("fault wrote register");

   property p_uflow_zero;
      cc_wr_en && cc_value == `FSL_CC_UFLOW && !arith_fault
         |-> fpr_wr_en && fpr_wr_data == 32'h00000000;
   endproperty
   a_uflow_zero: assert property (p_uflow_zero) else $error("underflow did not write zero");

   property p_positive_sign;
      legal_take && req.opcode == `FSL_OP_POS_REG
         |-> ##2 (arith_fault || (fpr_wr_en && !fpr_wr_data[31]));
   endproperty
   a_positive_sign: assert property (p_positive_sign) else $error("positive load negative");

   property p_norm_digit;
      fpr_wr_en && fpr_wr_data != 32'h00000000 && !$past(op_raw)
         |-> fpr_wr_data[23:20] != 4'h0;
   endproperty
   a_norm_digit: assert property (p_norm_digit) else $error("result not normalized");

   property p_apb_answer;
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing wrong");

   // a pending illegal event may only leave through a write of one to its status bit
   property p_status_sticky;
      r.status.illegal && !(apb_wr && paddr == `FSL_OFF_STATUS && pwdata[3])
         |=> r.status.illegal;
   endproperty
   a_status_sticky: assert property (p_status_sticky) else $error("status bit lost");

   c_fault:      cover property (arith_fault);
   c_uflow_zero: cover property (cc_wr_en && cc_value == `FSL_CC_UFLOW && fpr_wr_en);
   c_back2back:  cover property (legal_take ##2 legal_take);
   c_irq:        cover property (irq);
endmodule : fsl_load_unit

// *** rtl/fsl_regs.svh ***
// register offsets, field positions, reset values and opcodes of the fp load unit
`ifndef FSL_REGS_SVH
`define FSL_REGS_SVH

`define FSL_ADDR_W        8
`define FSL_OFF_CTRL      8'h00
`define FSL_OFF_STATUS    8'h04
`define FSL_OFF_MASK      8'h08
`define FSL_OFF_RESULT    8'h0C
`define FSL_OFF_CC        8'h10
`define FSL_OFF_COUNT     8'h14

`define FSL_CTRL_EN_BIT   0
`define FSL_CTRL_EN_RST   1'b1
`define FSL_EVT_W         4
`define FSL_STATUS_RST    4'h0
`define FSL_MASK_RST      4'h0

`define FSL_OP_RAW_MEM    8'h4E
`define FSL_OP_RAW_REG    8'h1E
`define FSL_OP_NORM_MEM   8'h68
`define FSL_OP_NORM_REG   8'h28
`define FSL_OP_NORM_GPR   8'hA5
`define FSL_OP_POS_REG    8'h13
`define FSL_OP_NEG_REG    8'h17

`define FSL_CC_ZERO       4'h0
`define FSL_CC_NEG        4'h1
`define FSL_CC_POS        4'h2
`define FSL_CC_UFLOW      4'h4

`endif

// *** rtl/fsl_pkg.sv ***
// types shared by the fp single load unit
package fsl_pkg;

   typedef enum logic [0:0] {
      ST_IDLE,
      ST_FETCH
   } fsl_state_t;

   typedef struct packed {
      logic [7:0]  opcode;       // instruction opcode
      logic [3:0]  dest;         // dest_reg_field
      logic [3:0]  src;          // src_reg_field
      logic [31:0] mem_data;     // fetched fullword for indexed storage forms
      logic        float_mask;   // float_mask_bit, status word bit 13
      logic        uflow_trap;   // status word bit 19
   } fsl_req_t;

   typedef struct packed {
      logic c;
      logic v;
      logic g;
      logic l;
   } fsl_cc_t;

   typedef struct packed {
      logic illegal;
      logic fault;
      logic uflow;
      logic done;
   } fsl_evt_t;

   typedef struct packed {
      fsl_state_t  st;
      fsl_req_t    req;
      logic        ready;
      logic [3:0]  fpr_rd_addr;
      logic [3:0]  gpr_rd_addr;
      logic        fpr_wr_en;
      logic [3:0]  fpr_wr_addr;
      logic [31:0] fpr_wr_data;
      logic        cc_wr_en;
      fsl_cc_t     cc;
      logic        fault;
      logic        illegal;
      logic        done;
      logic        enable;
      fsl_evt_t    status;
      fsl_evt_t    mask;
      logic [31:0] last_result;
      logic [31:0] op_count;
      logic        irq;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } fsl_ctx_t;

endpackage : fsl_pkg

// *** rtl/fsl_norm.sv ***
// hex normalizer for excess-64 single precision values
`timescale 1ns/1ps
module fsl_norm (
   input  wire logic [31:0] value_in,   // sign, 7-bit exponent, 24-bit fraction
   output logic      [31:0] result,     // normalized value, all zero on zero fraction
   output logic             underflow,  // exponent would go below zero
   output logic             frac_zero   // fraction of the input is zero
);
   logic [2:0]  lz;
   logic        found;
   logic [23:0] frac_sh;
   logic [7:0]  exp_new;

   always_comb begin
      lz    = 3'h0;
      found = 1'b0;
      for (int i = 5; i >= 0; i--) begin
         if (!found) begin
            if (value_in[i*4 +: 4] != 4'h0) begin
               found = 1'b1;
            end else begin
               lz = lz + 3'h1;
            end
         end
      end
      frac_zero = (value_in[23:0] == 24'h000000);
      frac_sh   = value_in[23:0] << {lz, 2'b00};
      exp_new   = {1'b0, value_in[30:24]} - {5'h00, lz};
      underflow = !frac_zero && ({4'h0, lz} > value_in[30:24]);
      // zero fraction forces sign and exponent to zero as well
      if (frac_zero) begin
         result = 32'h00000000;
      end else begin
         result = {value_in[31], exp_new[6:0], frac_sh};
      end
   end
endmodule : fsl_norm

// *** test/fsl_regfile_model.sv ***
// register file model at the far side of the fp load unit
`timescale 1ns/1ps
module fsl_regfile_model (
   input  wire logic        pclk,         // processor clock
   input  wire logic [3:0]  fpr_rd_addr,  // fpr read index
   output logic      [31:0] fpr_rd_data,  // fpr read data
   input  wire logic [3:0]  gpr_rd_addr,  // gpr read index
   output logic      [31:0] gpr_rd_data,  // gpr read data
   input  wire logic        fpr_wr_en,    // fpr write strobe
   input  wire logic [3:0]  fpr_wr_addr,  // fpr write index
   input  wire logic [31:0] fpr_wr_data   // fpr write data
);
   logic [31:0] fpr [16];
   logic [31:0] gpr [16];
   // odd fpr indices are undefined, so they read back bit-inverted instead of as a kind copy
   assign fpr_rd_data = fpr_rd_addr[0] ? ~fpr[fpr_rd_addr] : fpr[fpr_rd_addr];
   assign gpr_rd_data = gpr[gpr_rd_addr];
   always @(posedge pclk) begin
      if (fpr_wr_en) begin
         fpr[fpr_wr_addr] <= fpr_wr_data;
      end
   end
   initial begin
      for (int i = 0; i < 16; i++) begin
         fpr[i] = 32'h0000_0000;
         gpr[i] = 32'h0000_0000;
      end
   end
endmodule : fsl_regfile_model

// *** test/tb.sv ***
// self-checking bench for the fp single load unit
`timescale 1ns/1ps
`include "fsl_regs.svh"
module tb;
   logic              pclk = 1'b0;
   logic              presetn = 1'b0;
   logic              psel, penable, pwrite, req_valid;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, fpr_rd_data, gpr_rd_data, fpr_wr_data;
   logic              pready, pslverr, req_ready, fpr_wr_en, cc_wr_en;
   logic              arith_fault, illegal_op, done, irq, err;
   logic [3:0]        fpr_rd_addr, gpr_rd_addr, fpr_wr_addr;
   fsl_pkg::fsl_req_t req;
   fsl_pkg::fsl_cc_t  cc_value;
   int                miscompares = 0;
   int                compares = 0;
   int                cycles = 0;
   logic [31:0]       exp_count = 32'h0;
   logic [31:0]       last_wr = 32'h0;
   logic [31:0]       rd;

   always #5 pclk = ~pclk;

   fsl_load_unit u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .req_valid, .req, .req_ready, .fpr_rd_addr, .fpr_rd_data,
      .gpr_rd_addr, .gpr_rd_data, .fpr_wr_en, .fpr_wr_addr, .fpr_wr_data, .cc_wr_en,
      .cc_value, .arith_fault, .illegal_op, .done, .irq);
   fsl_regfile_model u_model (.pclk, .fpr_rd_addr, .fpr_rd_data, .gpr_rd_addr,
      .gpr_rd_data, .fpr_wr_en, .fpr_wr_addr, .fpr_wr_data);

   task automatic final_report;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         final_report;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         miscompares++;
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // excess-64 hex normalize; bit 32 flags underflow
   function automatic logic [32:0] norm(input logic [31:0] v);
      logic [23:0] f;
      int          e;
      f = v[23:0];
      e = v[30:24];
      if (f == 24'h0) return 33'h0;
      while (f[23:20] == 4'h0) begin
         f = f << 4;
         e--;
      end
      if (e < 0) return {1'b1, 32'h0};
      return {1'b0, v[31], e[6:0], f};
   endfunction : norm

   task automatic run(input logic [7:0] op, input logic [31:0] v, input logic trap,
                      input logic msk);
      logic [32:0] n;
      logic [31:0] s, ed, wd;
      logic [3:0]  ec, cv, wa;
      logic        legal, wr, flt, ill, dn, uft;
      legal = !msk && (op inside {`FSL_OP_RAW_MEM, `FSL_OP_RAW_REG, `FSL_OP_NORM_MEM,
         `FSL_OP_NORM_REG, `FSL_OP_NORM_GPR, `FSL_OP_POS_REG, `FSL_OP_NEG_REG});
      u_model.fpr[2] = (op == `FSL_OP_NORM_GPR) ? ~v : v;
      u_model.gpr[2] = (op == `FSL_OP_NORM_GPR) ? v : ~v;
      s = v;
      if (op == `FSL_OP_POS_REG) s[31] = 1'b0;
      if (op == `FSL_OP_NEG_REG) s[31] = ~v[31];
      n = (op == `FSL_OP_RAW_MEM || op == `FSL_OP_RAW_REG) ? {1'b0, s} : norm(s);
      ed = n[31:0];
      ec = n[32] ? `FSL_CC_UFLOW : (ed == 32'h0) ? `FSL_CC_ZERO :
           ed[31] ? `FSL_CC_NEG : `FSL_CC_POS;
      uft = n[32] & trap;
      @(posedge pclk);
      req_valid <= 1'b1;
      req <= '{opcode: op, dest: 4'h4, src: 4'h2, mem_data: v, float_mask: msk,
               uflow_trap: trap};
      @(posedge pclk);
      while (req_ready !== 1'b1) @(posedge pclk);
      req_valid <= 1'b0;
      {wr, flt, ill, dn} = 4'h0;
      // sample each cycle after the take edge; strobes stand one cycle only
      repeat (4) begin
         #1;
         if (fpr_wr_en === 1'b1) begin
            wr = 1'b1;
            wd = fpr_wr_data;
            wa = fpr_wr_addr;
         end
         if (cc_wr_en === 1'b1) cv = cc_value;
         if (arith_fault === 1'b1) flt = 1'b1;
         if (illegal_op === 1'b1) ill = 1'b1;
         if (done === 1'b1) dn = 1'b1;
         @(posedge pclk);
      end
      chk({31'h0, ill}, {31'h0, !legal});
      chk({31'h0, dn}, {31'h0, legal});
      chk({31'h0, flt}, {31'h0, legal & uft});
      chk({31'h0, wr}, {31'h0, legal & !uft});
      if (legal) begin
         chk({28'h0, cv}, {28'h0, ec});
         exp_count++;
         if (!uft) begin
            chk(wd, ed);
            chk({28'h0, wa}, 32'h4);
            last_wr = ed;
         end
      end
   endtask : run

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      req_valid = 1'b0;
      req = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `FSL_OFF_CTRL, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, `FSL_OFF_STATUS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, `FSL_OFF_MASK, 32'h0);
      chk(rd, 32'h0);
      run(`FSL_OP_RAW_MEM, 32'hC100_1234, 1'b0, 1'b0);
      run(`FSL_OP_RAW_REG, 32'h8000_0000, 1'b0, 1'b0);
      run(`FSL_OP_RAW_REG, 32'h0000_0000, 1'b0, 1'b0);
      run(`FSL_OP_NORM_MEM, 32'h4200_1000, 1'b0, 1'b0);
      run(`FSL_OP_NORM_REG, 32'hC200_0100, 1'b0, 1'b0);
      run(`FSL_OP_NORM_GPR, 32'h4112_3456, 1'b0, 1'b0);
      run(`FSL_OP_POS_REG, 32'hC119_21FB, 1'b0, 1'b0);
      run(`FSL_OP_NEG_REG, 32'h4101_2345, 1'b0, 1'b0);
      run(`FSL_OP_NEG_REG, 32'h8500_0000, 1'b0, 1'b0);
      run(`FSL_OP_POS_REG, 32'hFF00_0000, 1'b1, 1'b0);
      run(`FSL_OP_NORM_MEM, 32'h0100_1000, 1'b0, 1'b0);
      run(`FSL_OP_POS_REG, 32'h8100_1000, 1'b1, 1'b0);
      run(`FSL_OP_NORM_MEM, 32'h4200_1000, 1'b0, 1'b1);
      run(8'h4F, 32'h4110_0000, 1'b0, 1'b0);
      apb(1'b0, `FSL_OFF_RESULT, 32'h0);
      chk(rd, last_wr);
      apb(1'b1, `FSL_OFF_COUNT, 32'hFFFF_FFFF);
      apb(1'b0, `FSL_OFF_COUNT, 32'h0);
      chk(rd, exp_count);
      apb(1'b0, `FSL_OFF_STATUS, 32'h0);
      chk(rd, 32'hF);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, `FSL_OFF_MASK, 32'h8);
      repeat (2) @(posedge pclk);
      #1;
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, `FSL_OFF_STATUS, 32'h8);
      repeat (2) @(posedge pclk);
      #1;
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, `FSL_OFF_STATUS, 32'h0);
      chk(rd, 32'h7);
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, `FSL_OFF_CTRL, 32'h0);
      repeat (2) @(posedge pclk);
      #1;
      chk({31'h0, req_ready}, 32'h0);
      apb(1'b1, `FSL_OFF_CTRL, 32'h1);
      run(`FSL_OP_NORM_REG, 32'h3F00_0ABC, 1'b0, 1'b0);
      // nonzero last write, so a stuck result register cannot pass
      apb(1'b0, `FSL_OFF_RESULT, 32'h0);
      chk(rd, last_wr);
      apb(1'b0, `FSL_OFF_CC, 32'h0);
      chk(rd, {28'h0, `FSL_CC_POS});
      final_report;
   end
endmodule : tb
